// ===== rtl/tarb_result_buffer.sv
// 64-word conversion result buffer read by the host through a read-only register
// assumes results arrive as one-cycle strobes from the converter sequencer
`timescale 1ns/100ps
`include "tarb_params.svh"
// Functional notes
// (RULE1) reset clears full flag and sets empty flag in the data word
// (RULE2) buffer data register is read-only; host writes are ignored
// (RULE3) in buffer mode every completed result enters the buffer; code drops one arriving while full unless a read pops
// (RULE4) result sits right-justified in bits 11..0, flags and tag above
// (RULE5) full flag set exactly when all 64 entries hold unread data; code's data word full bit sets a cycle late and clears on every read
// (RULE6) empty flag set whenever no unread data remains
// (RULE7) word that drains the last entry already shows the empty flag
// (RULE8) tag low for X, Z1, battery, second_auxiliary_input; high for Y, Z2, first_auxiliary_input, temp
// (RULE9) touch results written Y,X or Y,X,Z1,Z2 or Z1,Z2
// (RULE10) auxiliary scan writes selected first_auxiliary_input, second_auxiliary_input, temperature in that order
// (RULE11) port scan writes battery, first_auxiliary_input, second_auxiliary_input
// (RULE12) each read returns and removes the oldest unread entry
module tarb_result_buffer (
    input wire logic clk,
    input wire logic rst,
    input wire logic buffer_mode_en,
    input wire logic scan_start,
    input wire logic [1:0] scan_kind,
    input wire logic res_valid,
    input wire tarb_pkg::tarb_source_type res_src,
    input wire logic [`TARB_VAL_W-1:0] conversion_result_value,
    input wire logic reg_read,
    input wire logic reg_write,
    input wire tarb_pkg::tarb_word_type reg_wdata,
    output tarb_pkg::tarb_word_type reg_rdata,
    output logic buffer_full_flag,
    output logic buffer_empty_flag,
    output logic order_error
);
    import tarb_pkg::*;

    // ****************************************
    // storage
    // ****************************************
    logic [`TARB_VAL_W:0] mem_q [`TARB_DEPTH];
    logic [`TARB_PTR_W-1:0] wr_ptr_q;
    logic [`TARB_PTR_W-1:0] rd_ptr_q;
    logic [`TARB_CNT_W-1:0] count_q;
    logic [`TARB_CNT_W-1:0] count_d;
    logic result_source_tag;
    logic do_push;
    logic do_pop;
    logic ord_err;

    tarb_tagger u_tagger (
        .src(res_src),
        .result_source_tag(result_source_tag)
    );

    tarb_order_check u_order (
        .clk(clk),
        .rst(rst),
        .scan_start(scan_start),
        .scan_kind(scan_kind),
        .res_valid(res_valid),
        .res_src(res_src),
        .order_error(ord_err)
    );

    // (RULE3) every result in buffer mode
    // a full buffer drops the newest result unless a read frees a slot in the same cycle
    assign do_push = buffer_mode_en && res_valid && ((count_q != `TARB_CNT_FULL) || do_pop);
    // (RULE12) read pops oldest
    assign do_pop = reg_read && (count_q != `TARB_CNT_ZERO);

    always_comb begin
        count_d = count_q;
        if (do_push && !do_pop) begin
            count_d = count_q + `TARB_CNT_ONE;
        end else if (do_pop && !do_push) begin
            count_d = count_q - `TARB_CNT_ONE;
        end
    end

    // (RULE8) tag stored with result
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= {result_source_tag, conversion_result_value};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= `TARB_PTR_ZERO;
            rd_ptr_q <= `TARB_PTR_ZERO;
            count_q <= `TARB_CNT_ZERO;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + `TARB_PTR_ONE;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + `TARB_PTR_ONE;
            end
            count_q <= count_d;
        end
    end

    // ****************************************
    // flags
    // ****************************************
    // (RULE5) full at 64 unread
    // (RULE6) empty when nothing unread
    always_ff @(posedge clk) begin
        if (rst) begin
            buffer_full_flag <= 1'b0;
            buffer_empty_flag <= 1'b1;
        end else begin
            buffer_full_flag <= (count_d == `TARB_CNT_FULL);
            buffer_empty_flag <= (count_d == `TARB_CNT_ZERO);
        end
    end

    // ****************************************
    // read data register
    // ****************************************
    // (RULE2) writes have no effect: reg_write and reg_wdata are never used to store
    // (RULE1) reset word
    // (RULE4) right-justified layout
    // (RULE7) draining read shows empty
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= `TARB_WORD_RESET;
        end else if (do_pop) begin
            reg_rdata[`TARB_BIT_FULL] <= 1'b0;
            reg_rdata[`TARB_BIT_EMPTY] <= (count_d == `TARB_CNT_ZERO);
            reg_rdata[`TARB_BIT_RSVD] <= 1'b0;
            reg_rdata[`TARB_BIT_TAG:0] <= mem_q[rd_ptr_q];
        end else if (reg_read) begin
            reg_rdata[`TARB_BIT_FULL] <= 1'b0;
            reg_rdata[`TARB_BIT_EMPTY] <= 1'b1;
        end else begin
            reg_rdata[`TARB_BIT_FULL] <= (count_q == `TARB_CNT_FULL);
            reg_rdata[`TARB_BIT_EMPTY] <= (count_q == `TARB_CNT_ZERO);
        end
    end

    // (RULE10) aux scan order checked
    always_ff @(posedge clk) begin
        if (rst) begin
            order_error <= 1'b0;
        end else begin
            order_error <= ord_err;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // full tracks count
    full_flag_a: assert property (@(posedge clk) disable iff (rst)
        ##1 buffer_full_flag == (count_q == `TARB_CNT_FULL)) // RULE5
        else $error("full flag disagrees with count");
    empty_flag_a: assert property (@(posedge clk) disable iff (rst)
        ##1 buffer_empty_flag == (count_q == `TARB_CNT_ZERO)) // RULE6
        else $error("empty flag disagrees with count");
    drain_empty_a: assert property (@(posedge clk) disable iff (rst)
        (reg_read && count_q == `TARB_CNT_ONE && !do_push) |=> reg_rdata[`TARB_BIT_EMPTY]) // RULE7
        else $error("draining read lacks empty flag");
    reset_word_a: assert property (@(posedge clk)
        rst |=> (reg_rdata[`TARB_BIT_EMPTY] && !reg_rdata[`TARB_BIT_FULL])) // RULE1
        else $error("reset word flags wrong");
    push_count_a: assert property (@(posedge clk) disable iff (rst)
        (buffer_mode_en && res_valid && !reg_read && count_q < `TARB_CNT_FULL)
        |=> count_q == $past(count_q) + `TARB_CNT_ONE) // RULE3
        else $error("result not stored");
    write_ignored_a: assert property (@(posedge clk) disable iff (rst)
        (reg_write && !reg_read) |=> $stable(reg_rdata[`TARB_VAL_MSB:0])) // RULE2
        else $error("host write changed data");
    pop_order_a: assert property (@(posedge clk) disable iff (rst)
        do_pop |=> rd_ptr_q == $past(rd_ptr_q) + `TARB_PTR_ONE) // RULE12
        else $error("read did not advance");
    pop_data_a: assert property (@(posedge clk) disable iff (rst)
        do_pop |=> reg_rdata[`TARB_BIT_TAG:0] == $past(mem_q[rd_ptr_q])) // RULE4
        else $error("read word not oldest entry");
    tag_a: assert property (@(posedge clk) disable iff (rst)
        (res_src == TARB_SRC_X || res_src == TARB_SRC_BAT) |-> !result_source_tag) // RULE8
        else $error("tag high for low source");
    order_a: assert property (@(posedge clk) disable iff (rst)
        (scan_start && scan_kind == 2'h0) ##1 (!scan_start && !res_valid)
        ##1 (!scan_start && res_valid && res_src == TARB_SRC_X)
        |=> ##1 order_error) // RULE9
        else $error("bad touch order not flagged");
    rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
        !reg_rdata[`TARB_BIT_RSVD]) // RULE4
        else $error("reserved bit not zero");
    mode_off_a: assert property (@(posedge clk) disable iff (rst)
        (!buffer_mode_en && !reg_read) |=> $stable(count_q)) // RULE3
        else $error("result stored outside buffer mode");
    order_c: cover property (@(posedge clk) disable iff (rst) order_error);
    full_swap_c: cover property (@(posedge clk) disable iff (rst)
        do_push && do_pop && count_q == `TARB_CNT_FULL);
    fill_c: cover property (@(posedge clk) disable iff (rst) buffer_full_flag);
    drain_c: cover property (@(posedge clk) disable iff (rst)
        do_pop && count_q == `TARB_CNT_ONE);
    both_c: cover property (@(posedge clk) disable iff (rst) do_push && do_pop);
endmodule // tarb_result_buffer

// ===== rtl/tarb_params.svh
// constants of the touch converter result buffer
// assumes inclusion by the package and the design modules
`ifndef TARB_PARAMS_SVH
`define TARB_PARAMS_SVH
`define TARB_DEPTH 64
`define TARB_PTR_W 6
`define TARB_CNT_W 7
`define TARB_WORD_W 16
`define TARB_VAL_W 12
`define TARB_BIT_FULL 15
`define TARB_BIT_EMPTY 14
`define TARB_BIT_RSVD 13
`define TARB_BIT_TAG 12
`define TARB_VAL_MSB 11
`define TARB_CNT_ZERO 7'h00
`define TARB_CNT_ONE 7'h01
`define TARB_CNT_FULL 7'h40
`define TARB_PTR_ZERO 6'h00
`define TARB_PTR_ONE 6'h01
`define TARB_WORD_RESET 16'h4000
`endif

// ===== rtl/tarb_pkg.sv
// types shared by the result buffer modules
// assumes tarb_params.svh is on the include path
`include "tarb_params.svh"
package tarb_pkg;
    // kind of measurement that produced a result
    typedef enum logic [3:0] {
        TARB_SRC_X,
        TARB_SRC_Y,
        TARB_SRC_Z1,
        TARB_SRC_Z2,
        TARB_SRC_BAT,
        TARB_SRC_FIRST_AUXILIARY_INPUT,
        TARB_SRC_SECOND_AUXILIARY_INPUT,
        TARB_SRC_TEMP
    } tarb_source_type;
    typedef logic [`TARB_WORD_W-1:0] tarb_word_type;
endpackage

// ===== rtl/tarb_tagger.sv
// maps a measurement kind to the source tag bit
// assumes a source kind from the converter sequencer
`timescale 1ns/100ps
`include "tarb_params.svh"
module tarb_tagger (
    input wire tarb_pkg::tarb_source_type src,
    output logic result_source_tag
);
    import tarb_pkg::*;
    // (RULE8) tag per source
    always_comb begin
        case (src)
            TARB_SRC_Y, TARB_SRC_Z2, TARB_SRC_FIRST_AUXILIARY_INPUT, TARB_SRC_TEMP: result_source_tag = 1'b1;
            default: result_source_tag = 1'b0;
        endcase
    end
endmodule // tarb_tagger

// ===== rtl/tarb_order_check.sv
// tracks the expected source order inside a multi-result scan
// assumes scan_start pulses before the first result of each scan
`timescale 1ns/100ps
`include "tarb_params.svh"
module tarb_order_check (
    input wire logic clk,
    input wire logic rst,
    input wire logic scan_start,
    input wire logic [1:0] scan_kind,
    input wire logic res_valid,
    input wire tarb_pkg::tarb_source_type res_src,
    output logic order_error
);
    import tarb_pkg::*;
    logic [1:0] step_q;
    logic [1:0] kind_q;
    tarb_source_type expect_src;
    logic aux_seen_q;
    tarb_source_type aux_last_q;
    logic aux_bad;
    // (RULE10) aux scan only first_auxiliary_input, second_auxiliary_input, temperature, strictly in that order
    assign aux_bad = !(res_src inside {TARB_SRC_FIRST_AUXILIARY_INPUT, TARB_SRC_SECOND_AUXILIARY_INPUT, TARB_SRC_TEMP})
        || (aux_seen_q && (res_src <= aux_last_q));
    always_ff @(posedge clk) begin
        if (rst || scan_start) begin
            aux_seen_q <= 1'b0;
            aux_last_q <= TARB_SRC_X;
        end else if (res_valid) begin
            aux_seen_q <= 1'b1;
            aux_last_q <= res_src;
        end
    end
    always_comb begin
        case ({kind_q, step_q})
            4'h0: expect_src = TARB_SRC_Y;
            4'h1: expect_src = TARB_SRC_X;
            4'h2: expect_src = TARB_SRC_Z1;
            4'h3: expect_src = TARB_SRC_Z2;
            4'h4: expect_src = TARB_SRC_Z1;
            4'h5: expect_src = TARB_SRC_Z2;
            4'h8: expect_src = TARB_SRC_BAT;
            4'h9: expect_src = TARB_SRC_FIRST_AUXILIARY_INPUT;
            4'ha: expect_src = TARB_SRC_SECOND_AUXILIARY_INPUT;
            default: expect_src = res_src;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst || scan_start) begin
            step_q <= 2'h0;
            kind_q <= scan_kind;
        end else if (res_valid) begin
            step_q <= step_q + 2'h1;
        end
    end
    // (RULE9) touch order flagged
    // (RULE11) port scan order flagged
    always_ff @(posedge clk) begin
        if (rst) begin
            order_error <= 1'b0;
        end else begin
            order_error <= res_valid && ((kind_q == 2'h3) ? aux_bad : (res_src != expect_src));
        end
    end
endmodule // tarb_order_check

// ===== test/tarb_host_model.sv
// host side model: reads and writes the result buffer data register
// assumes the bench clock and the buffer's register strobes
`timescale 1ns/100ps
module tarb_host_model (
    input wire logic clk,
    output logic reg_read,
    output logic reg_write,
    output tarb_pkg::tarb_word_type reg_wdata,
    input wire tarb_pkg::tarb_word_type reg_rdata
);
    import tarb_pkg::*;
    // ****************
    // register strobes
    // ****************
    initial begin
        reg_read = 1'b0;
        reg_write = 1'b0;
        reg_wdata = 16'h0000;
    end
    task automatic rd(output tarb_word_type w);
        @(posedge clk);
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        // the popped word lands on the sampling edge itself
        #1 w = reg_rdata;
    endtask
    task automatic wr(input tarb_word_type d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        // released data lines do not keep the last value
        reg_wdata <= ~d;
    endtask
endmodule // tarb_host_model

// ===== test/touch_adc_result_buffer_test.sv
// self-checking bench of the result buffer with random results
// assumes the host model drives the register strobes
`timescale 1ns/100ps
module touch_adc_result_buffer_test;
    import tarb_pkg::*;
    logic clk, rst, mode, start, valid, rd, wr, full, empty, oerr, err_seen;
    logic [1:0] kind;
    logic [11:0] val;
    tarb_source_type src;
    tarb_word_type wdata, rdata, w;
    int bad_count, samples_checked;
    logic [12:0] q[$];
    // ***********
    // connections
    // ***********
    tarb_result_buffer uut (.clk(clk), .rst(rst), .buffer_mode_en(mode), .scan_start(start),
        .scan_kind(kind), .res_valid(valid), .res_src(src), .conversion_result_value(val),
        .reg_read(rd), .reg_write(wr), .reg_wdata(wdata), .reg_rdata(rdata),
        .buffer_full_flag(full), .buffer_empty_flag(empty), .order_error(oerr));
    tarb_host_model host (.clk(clk), .reg_read(rd), .reg_write(wr), .reg_wdata(wdata),
        .reg_rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // flag is cleared by the scan start strobe so each scan is judged on its own
    always @(posedge clk) begin
        if (start === 1'b1) err_seen <= 1'b0;
        else if (oerr === 1'b1) err_seen <= 1'b1;
    end
    // *******
    // helpers
    // *******
    function logic tag_of(tarb_source_type s);
        return s inside {TARB_SRC_Y, TARB_SRC_Z2, TARB_SRC_FIRST_AUXILIARY_INPUT, TARB_SRC_TEMP};
    endfunction
    function tarb_source_type src_of(int k, int i);
        case (k)
            0: return tarb_source_type'(i == 0 ? 1 : (i == 1 ? 0 : i));
            1: return tarb_source_type'(i + 2);
            2: return tarb_source_type'(i + 4);
            default: return tarb_source_type'(i + 5);
        endcase
    endfunction
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // hold keeps the strobe up so results can arrive every cycle
    task push(input tarb_source_type s, input logic hold);
        logic [11:0] v;
        v = 12'($urandom);
        @(posedge clk);
        valid <= 1'b1;
        src <= s;
        val <= v;
        if (mode && q.size() < 64) q.push_back({tag_of(s), v});
        if (!hold) begin
            @(posedge clk);
            valid <= 1'b0;
        end
    endtask
    task scan(input int k, input int n, input logic bad);
        @(posedge clk);
        start <= 1'b1;
        kind <= 2'(k);
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < n; i++) push(src_of(k, bad ? n - 1 - i : i), 1'b0);
        repeat (3) @(posedge clk);
        chk({15'h0000, err_seen}, {15'h0000, bad});
    endtask
    task drain;
        logic [12:0] e;
        while (q.size() > 0) begin
            host.rd(w);
            e = q.pop_front();
            chk(w, {1'b0, q.size() == 0, 1'b0, e});
        end
    endtask
    task tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ********
    // sequence
    // ********
    initial begin
        #(50 * 20000);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        rst = 1'b1;
        mode = 1'b0;
        start = 1'b0;
        valid = 1'b0;
        kind = 2'h0;
        val = 12'h000;
        src = TARB_SRC_X;
        bad_count = 0;
        samples_checked = 0;
        void'($urandom(94772));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk(rdata, 16'h4000);
        chk({14'h0000, full, empty}, 16'h0001);
        host.wr(16'hffff);
        #1 chk(rdata, 16'h4000);
        @(posedge clk);
        mode <= 1'b0;
        push(TARB_SRC_Y, 1'b0);
        @(posedge clk);
        mode <= 1'b1;
        #1 chk({15'h0000, empty}, 16'h0001);
        for (int k = 0; k < 4; k++) scan(k, k == 0 ? 4 : (k == 1 ? 2 : 3), 1'b0);
        scan(0, 2, 1'b0);
        scan(2, 3, 1'b1);
        scan(1, 2, 1'b1);
        scan(0, 2, 1'b1);
        scan(3, 2, 1'b1);
        drain;
        repeat (65) push(tarb_source_type'($urandom_range(7)), 1'b1);
        @(posedge clk);
        valid <= 1'b0;
        @(posedge clk);
        #1 chk({14'h0000, full, rdata[15]}, 16'h0003);
        drain;
        chk({14'h0000, full, empty}, 16'h0001);
        tally_and_finish;
    end
endmodule // touch_adc_result_buffer_test
